//--- icap_pkg.sv
// Purpose: constants for the indirect configuration access port
// Assumes: 32-bit processor data bus, little-endian lane numbering
// Notes: addresses are compared on word addresses (byte address bits 31:2)
package icap_pkg;

  // address map selection
  typedef enum logic [1:0] {
    ICAP_MAP_A = 2'h0,
    ICAP_MAP_B = 2'h1,
    ICAP_MAP_EMU = 2'h3
  } icap_map_t;

  // map A, contiguous and discontiguous
  localparam logic [31:0] PTR_ADDR_A = 32'h8000_0CF8;
  localparam logic [31:0] WIN_ADDR_A = 32'h8000_0CFC;
  localparam logic [31:0] PTR_ADDR_A_DISC = 32'h8006_7018;
  localparam logic [31:0] WIN_ADDR_A_DISC = 32'h8006_701C;

  // map A fixed compatibility bytes
  localparam int COMPAT_N = 3;
  localparam logic [31:0] COMPAT_ADDR [COMPAT_N] = '{
    32'h8000_0092, 32'h8000_081C, 32'h8000_0850
  };
  localparam logic [7:0] COMPAT_RESET = 8'h00;

  // map B and emulation map alias ranges, upper bits of the byte address
  localparam logic [10:0] PTR_RANGE_B = 11'h7F6;
  localparam int PTR_RANGE_LSB = 21;
  localparam logic [11:0] WIN_RANGE_B = 12'hFEE;
  localparam int WIN_RANGE_LSB = 20;

  // pointer layout and reset
  localparam logic [31:0] PTR_RESET = 32'h0000_0000;
  localparam int PTR_OFF_MSB = 7;
  localparam int PTR_OFF_LSB = 2;

  // configuration space: 256 bytes as 64 words
  localparam int CFG_AW = 6;
  localparam int CFG_WORDS = 64;

endpackage

//--- icap_cfg_mem.sv
// Purpose: configuration register storage with byte lane writes
// Assumes: one write port, one read port, same clock
// Notes: read data comes out of a register one edge after the address
`timescale 1ns/1ns
module icap_cfg_mem (
  // clock
  input wire logic sys_clk,
  // write port
  input wire logic [3:0] wr_be,
  input wire logic [icap_pkg::CFG_AW-1:0] wr_addr,
  input wire logic [31:0] wr_data,
  // read port
  input wire logic [icap_pkg::CFG_AW-1:0] rd_addr,
  output logic [31:0] rd_data_q
);

  // lane i always lands in register byte i: storage stays little-endian
  // one byte array per lane, so each array has a single writing process
  for (genvar i = 0; i < 4; i++) begin : g_lane
    logic [7:0] lane_mem [icap_pkg::CFG_WORDS];

    always_ff @(posedge sys_clk) begin
      if (wr_be[i]) begin
        lane_mem[wr_addr] <= wr_data[8*i +: 8]; // [RULE8] [RULE11]
      end
    end

    always_ff @(posedge sys_clk) begin
      rd_data_q[8*i +: 8] <= lane_mem[rd_addr];
    end
  end

endmodule

//--- icap_top.sv
// Purpose: indirect access to internal configuration registers via pointer and data window
// Assumes: processor bus on sys_clk, map and mode straps are asynchronous pins
// Notes: answers come two edges after a request, claimed or not
//
// Notes on behaviour
// [RULE1] map A: word write at 0x8000_0CF8 loads pointer; next word is data window.
// [RULE2] map A discontiguous: pointer at 0x8006_7018, window 0x8006_701C to 0x8006_701F.
// [RULE3] software writes pointer as 0x8000_00 plus word-aligned register offset.
// [RULE4] maps B and emulation: any word 0xFEC0_0000 to 0xFEDF_FFFF is the pointer.
// [RULE5] maps B and emulation: any address 0xFEE0_0000 to 0xFEEF_FFFF is the window.
// [RULE6] map A: three fixed compatibility addresses reach configuration bits directly.
// [RULE7] window byte lane adds to pointer offset to select the register byte.
// [RULE8] byte or halfword window writes change only the addressed register bytes.
// [RULE9] little-endian software presents pointer and data least significant byte first.
// [RULE10] big-endian software byte-swaps register data before window accesses.
// [RULE11] registers are stored little-endian whatever the endian mode.
// [RULE12] big-endian software also byte-swaps the pointer value under every map.
// [RULE13] pointer holds its value until rewritten, serving many window accesses.
`timescale 1ns/1ns
module icap_top (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // mode straps, asynchronous
  input wire logic [1:0] map_sel,
  input wire logic discontig_mode,
  // processor bus request
  input wire logic bus_req,
  input wire logic bus_we,
  input wire logic [31:0] bus_addr,
  input wire logic [3:0] bus_be,
  input wire logic [31:0] bus_wdata,
  // processor bus answer
  output logic bus_ack_q,
  output logic bus_hit_q,
  output logic [31:0] bus_rdata_q,
  // state seen by the rest of the bridge
  output logic [31:0] cfg_ptr_q,
  output logic [8*icap_pkg::COMPAT_N-1:0] compat_bits_q
);

  // strap synchronisers
  logic [1:0] map_meta_q;
  logic [1:0] map_sync_q;
  logic disc_meta_q;
  logic disc_sync_q;

  // reset holds map A until the straps have passed both flops
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      map_meta_q <= 2'h0;
      map_sync_q <= 2'h0;
    end else begin
      map_meta_q <= map_sel;
      map_sync_q <= map_meta_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      disc_meta_q <= 1'b0;
      disc_sync_q <= 1'b0;
    end else begin
      disc_meta_q <= discontig_mode;
      disc_sync_q <= disc_meta_q;
    end
  end

  // address decode
  logic map_a;
  logic [29:0] word_addr;
  logic ptr_hit;
  logic win_hit;
  logic [icap_pkg::COMPAT_N-1:0] compat_hit;

  assign map_a = (map_sync_q == icap_pkg::ICAP_MAP_A);
  assign word_addr = bus_addr[31:2];

  // request qualifiers, one request per cycle with bus_req high
  logic wr_req;
  logic rd_req;

  assign wr_req = bus_req && bus_we;
  assign rd_req = bus_req && !bus_we;

  always_comb begin
    ptr_hit = 1'b0;
    win_hit = 1'b0;
    if (map_a) begin
      if (disc_sync_q) begin
        ptr_hit = (word_addr == icap_pkg::PTR_ADDR_A_DISC[31:2]); // [RULE2]
        win_hit = (word_addr == icap_pkg::WIN_ADDR_A_DISC[31:2]); // [RULE2]
      end else begin
        ptr_hit = (word_addr == icap_pkg::PTR_ADDR_A[31:2]); // [RULE1]
        win_hit = (word_addr == icap_pkg::WIN_ADDR_A[31:2]); // [RULE1]
      end
    end else begin
      // every word in each range aliases the same place
      ptr_hit = (bus_addr[31:icap_pkg::PTR_RANGE_LSB] == icap_pkg::PTR_RANGE_B); // [RULE4]
      win_hit = (bus_addr[31:icap_pkg::WIN_RANGE_LSB] == icap_pkg::WIN_RANGE_B); // [RULE5]
    end
  end

  // compatibility bytes: each sits in the lane its byte address names
  logic [8*icap_pkg::COMPAT_N-1:0] compat_rd;

  for (genvar c = 0; c < icap_pkg::COMPAT_N; c++) begin : g_compat
    localparam logic [31:0] CA = icap_pkg::COMPAT_ADDR[c];
    assign compat_hit[c] = map_a && (word_addr == CA[31:2])
                           && bus_be[CA[1:0]]; // [RULE6]
    assign compat_rd[8*c +: 8] = compat_bits_q[8*c +: 8];

    always_ff @(posedge sys_clk) begin
      if (rst) begin
        compat_bits_q[8*c +: 8] <= icap_pkg::COMPAT_RESET;
      end else if (bus_req && bus_we && compat_hit[c]) begin
        compat_bits_q[8*c +: 8] <= bus_wdata[8*CA[1:0] +: 8]; // [RULE6]
      end
    end
  end

  // pointer: bytes follow the byte enables, value held until rewritten
  for (genvar b = 0; b < 4; b++) begin : g_ptr
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        cfg_ptr_q[8*b +: 8] <= icap_pkg::PTR_RESET[8*b +: 8];
      end else if (bus_req && bus_we && ptr_hit && bus_be[b]) begin
        cfg_ptr_q[8*b +: 8] <= bus_wdata[8*b +: 8]; // [RULE1] [RULE4] [RULE13]
      end
    end
  end

  // configuration storage, word chosen by the pointer, byte by the lane
  logic [3:0] mem_be;
  logic [31:0] mem_rdata;
  logic [icap_pkg::CFG_AW-1:0] cfg_word;

  // the word-aligned offset plus lane number yields the register byte
  assign cfg_word = cfg_ptr_q[icap_pkg::PTR_OFF_MSB:icap_pkg::PTR_OFF_LSB]; // [RULE7] [RULE13]
  assign mem_be = (wr_req && win_hit) ? bus_be : 4'h0; // [RULE8]

  icap_cfg_mem u_mem (
    .sys_clk(sys_clk),
    .wr_be(mem_be),
    .wr_addr(cfg_word),
    .wr_data(bus_wdata),
    .rd_addr(cfg_word),
    .rd_data_q(mem_rdata)
  );

  // first answer stage: remember what the request hit
  logic any_hit;
  logic s1_valid_q;
  logic s1_hit_q;
  logic s1_rd_win_q;
  logic [3:0] s1_be_q;
  logic [31:0] s1_rdata_q;

  // unclaimed requests are still answered, so a stray address never hangs the bus
  assign any_hit = ptr_hit || win_hit || (|compat_hit);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s1_valid_q <= 1'b0;
      s1_hit_q <= 1'b0;
      s1_rd_win_q <= 1'b0;
      s1_be_q <= 4'h0;
    end else begin
      s1_valid_q <= bus_req;
      s1_hit_q <= bus_req && any_hit;
      s1_rd_win_q <= rd_req && win_hit;
      s1_be_q <= bus_be;
    end
  end

  // pointer and compatibility reads are picked here; window data comes from the store
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s1_rdata_q <= 32'h0000_0000;
    end else begin
      s1_rdata_q <= 32'h0000_0000;
      if (rd_req && ptr_hit) begin
        s1_rdata_q <= cfg_ptr_q;
      end
      for (int c = 0; c < icap_pkg::COMPAT_N; c++) begin
        if (rd_req && compat_hit[c]) begin
          s1_rdata_q[8*icap_pkg::COMPAT_ADDR[c][1:0] +: 8] <= compat_rd[8*c +: 8];
        end
      end
    end
  end

  // second stage: answer, lanes not enabled read as zero
  logic [31:0] lane_mask;

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      lane_mask[8*b +: 8] = {8{s1_be_q[b]}};
    end
  end

  // fixed two-edge latency: nothing stalls, so no request is ever held off
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bus_ack_q <= 1'b0;
      bus_hit_q <= 1'b0;
    end else begin
      bus_ack_q <= s1_valid_q;
      bus_hit_q <= s1_hit_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bus_rdata_q <= 32'h0000_0000;
    end else if (s1_rd_win_q) begin
      bus_rdata_q <= mem_rdata & lane_mask; // [RULE7] [RULE11]
    end else begin
      bus_rdata_q <= s1_rdata_q & lane_mask;
    end
  end

endmodule

//--- icap_asserts.sv
// Purpose: checks on bus answers and pointer decode
// Assumes: straps steady three edges before they are relied on
// Notes: a strap history stands in for the design's sync delay
`timescale 1ns/1ns
module icap_asserts (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // straps and request
  input wire logic [1:0] map_sel,
  input wire logic discontig_mode,
  input wire logic bus_req,
  input wire logic bus_we,
  input wire logic [31:0] bus_addr,
  input wire logic [3:0] bus_be,
  input wire logic [31:0] bus_wdata,
  // answer and state
  input wire logic bus_ack_q,
  input wire logic bus_hit_q,
  input wire logic [31:0] cfg_ptr_q,
  input wire logic [8*icap_pkg::COMPAT_N-1:0] compat_bits_q
);
  logic [8:0] h_q;
  logic [2:0] cur;
  logic [2:0] ok;
  logic wr;
  assign cur = {map_sel == 2'h0 && !discontig_mode, map_sel == 2'h0 && discontig_mode,
                map_sel != 2'h0};
  // a strap counts only once it has been steady past the sync flops
  assign ok = cur & h_q[8:6] & h_q[5:3] & h_q[2:0];
  assign wr = bus_req && bus_we && bus_be == 4'hF;
  always_ff @(posedge sys_clk) begin
    h_q <= {h_q[5:0], cur};
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_ack_delay:
    assert property (bus_req |-> ##2 bus_ack_q) else $error("ack late");
  a_ack_cause:
    assert property (bus_ack_q |-> $past(bus_req, 2)) else $error("ack unasked");
  a_ptr_map_a:
    assert property (wr && ok[2] && bus_addr == icap_pkg::PTR_ADDR_A
      |=> cfg_ptr_q == $past(bus_wdata) ##1 bus_hit_q) else $error("ptr map A");
  a_ptr_disc:
    assert property (wr && ok[1] && bus_addr == icap_pkg::PTR_ADDR_A_DISC
      |=> cfg_ptr_q == $past(bus_wdata) ##1 bus_hit_q) else $error("ptr disc");
  a_disc_drop:
    assert property (bus_req && ok[1] && bus_addr == icap_pkg::PTR_ADDR_A
      |-> ##2 !bus_hit_q) else $error("old ptr claimed");
  a_ptr_alias:
    assert property (wr && ok[0] && bus_addr[31:21] == icap_pkg::PTR_RANGE_B && !bus_addr[1:0]
      |=> cfg_ptr_q == $past(bus_wdata)) else $error("ptr alias");
  a_win_alias:
    assert property (bus_req && ok[0] && bus_addr[31:20] == icap_pkg::WIN_RANGE_B
      |-> ##2 bus_hit_q) else $error("window alias");
  a_compat_lane:
    assert property (bus_req && bus_we && ok[2] && bus_addr == icap_pkg::COMPAT_ADDR[0]
      && bus_be == 4'h4 |=> compat_bits_q[7:0] == $past(bus_wdata[23:16]))
      else $error("compat byte");
  a_ptr_hold:
    assert property (!(bus_req && bus_we) |=> $stable(cfg_ptr_q)) else $error("ptr moved");
endmodule
bind icap_top icap_asserts u_chk (.*);

//--- icap_cpu.sv
// Purpose: processor bus master model
// Assumes: one request per strobe, answer within four edges
// Notes: idle address and data show the inverse of the last value
`timescale 1ns/1ns
module icap_cpu (
  // clock
  input wire logic sys_clk,
  // request
  output logic bus_req,
  output logic bus_we,
  output logic [31:0] bus_addr,
  output logic [3:0] bus_be,
  output logic [31:0] bus_wdata,
  // answer
  input wire logic bus_ack_q,
  input wire logic bus_hit_q,
  input wire logic [31:0] bus_rdata_q
);
  initial begin
    {bus_req, bus_we, bus_addr, bus_be, bus_wdata} = '0;
  end
  task automatic xfer(input logic we, input logic [31:0] a, input logic [3:0] be,
      input logic [31:0] wd, output logic [31:0] rd, output logic hit, output logic ok);
    ok = 1'b0;
    @(posedge sys_clk);
    {bus_req, bus_we, bus_addr, bus_be, bus_wdata} <= {1'b1, we, a, be, wd};
    @(posedge sys_clk);
    {bus_req, bus_addr, bus_wdata} <= {1'b0, ~a, ~wd};
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge sys_clk);
      #1;
      ok = bus_ack_q === 1'b1;
      rd = bus_rdata_q;
      hit = bus_hit_q;
    end
  endtask
endmodule

//--- testbench.sv
// Purpose: directed tests of the configuration access port
// Assumes: straps change only while the bus is idle
// Notes: big-endian cases swap bytes in software
`timescale 1ns/1ns
module testbench;
  logic sys_clk;
  logic rst;
  logic [1:0] map_sel;
  logic discontig_mode;
  logic bus_req, bus_we, bus_ack_q, bus_hit_q, hit, ok;
  logic [31:0] bus_addr, bus_wdata, bus_rdata_q, cfg_ptr_q, rd;
  logic [3:0] bus_be;
  logic [8*icap_pkg::COMPAT_N-1:0] compat_bits_q;
  int n_mismatch = 0;
  int comparisons = 0;
  icap_top dut (.*);
  icap_cpu cpu (.*);
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic ax(input logic we, input logic [31:0] a, input logic [3:0] be,
      input logic [31:0] wd, input logic hx);
    cpu.xfer(we, a, be, wd, rd, hit, ok);
    if (!ok) begin
      n_mismatch++;
      test_done();
    end
    chk("hit", {31'h0, hit}, {31'h0, hx});
  endtask
  task automatic straps(input logic [1:0] m, input logic d);
    @(posedge sys_clk);
    map_sel <= m;
    discontig_mode <= d;
    repeat (4) @(posedge sys_clk);
  endtask
  // pointer word: fixed upper bits, register offset in the low byte
  function automatic logic [31:0] ptr(input logic [7:0] off);
    return {24'h8000_00, off[7:2], 2'h0};
  endfunction
  // big-endian software hands over byte-swapped words
  function automatic logic [31:0] swp(input logic [31:0] v);
    return {v[7:0], v[15:8], v[23:16], v[31:24]};
  endfunction
  initial begin
    rst = 1'b1;
    map_sel = 2'h0;
    discontig_mode = 1'b0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    ax(1, icap_pkg::PTR_ADDR_A, 4'hF, ptr(8'hA8), 1);
    chk("ptr", cfg_ptr_q, 32'h8000_00A8);
    ax(0, icap_pkg::PTR_ADDR_A, 4'hF, 0, 1);
    chk("ptr read", rd, 32'h8000_00A8);
    ax(1, icap_pkg::WIN_ADDR_A, 4'hF, 32'hAABB_CCDD, 1);
    ax(0, icap_pkg::WIN_ADDR_A + 1, 4'h2, 0, 1);
    chk("byte A9", rd, 32'h0000_CC00);
    ax(1, icap_pkg::WIN_ADDR_A, 4'hF, 32'hFFFF_FFFF, 1);
    ax(1, icap_pkg::WIN_ADDR_A + 2, 4'hC, 32'hCCDD_0000, 1);
    ax(0, icap_pkg::WIN_ADDR_A, 4'hF, 0, 1);
    chk("half AA", rd, 32'hCCDD_FFFF);
    ax(0, 32'h8000_0D00, 4'hF, 0, 0);
    chk("unclaimed", rd, 32'h0000_0000);
    for (int i = 0; i < icap_pkg::COMPAT_N; i++) begin
      ax(1, icap_pkg::COMPAT_ADDR[i], 4'h1 << icap_pkg::COMPAT_ADDR[i][1:0],
         32'h1111_1111 * (i + 1), 1);
      chk("compat", {24'h0, compat_bits_q[8*i +: 8]}, 32'h11 * (i + 1));
    end
    ax(1, icap_pkg::COMPAT_ADDR[0], 4'h1, 0, 0);
    chk("compat kept", {24'h0, compat_bits_q[7:0]}, 32'h11);
    ax(0, icap_pkg::COMPAT_ADDR[0], 4'h4, 0, 1);
    chk("compat read", rd, 32'h0011_0000);
    $display("map A done");
    straps(2'h0, 1'b1);
    ax(1, icap_pkg::PTR_ADDR_A_DISC, 4'hF, ptr(8'hAC), 1);
    ax(1, icap_pkg::PTR_ADDR_A, 4'hF, 0, 0);
    chk("ptr disc", cfg_ptr_q, 32'h8000_00AC);
    ax(1, icap_pkg::WIN_ADDR_A_DISC + 3, 4'h8, 32'h7700_0000, 1);
    ax(0, icap_pkg::WIN_ADDR_A_DISC, 4'h8, 0, 1);
    chk("disc AF", rd, 32'h7700_0000);
    $display("discontiguous done");
    for (int i = 0; i < 3; i++) begin
      straps(i == 0 ? 2'h1 : (i == 1 ? 2'h3 : 2'h2), 1'b0);
      ax(1, i[0] ? 32'hFEC0_0000 : 32'hFEDF_FFFC, 4'hF, swp(32'hA800_0080), 1);
      chk("ptr B", cfg_ptr_q, 32'h8000_00A8);
      ax(1, i[0] ? 32'hFEE0_0000 : 32'hFEEF_FFFC, 4'hF, swp(32'hDDCC_BBAA), 1);
      ax(0, i[0] ? 32'hFEEF_FFFC : 32'hFEE0_0000, 4'hF, 0, 1);
      chk("data B", rd, 32'hAABB_CCDD);
      ax(1, i[0] ? 32'hFEE0_0002 : 32'hFEEF_FFFE, 4'h4, 32'h00EE_0000, 1);
      ax(0, 32'hFEE4_0000, 4'hF, 0, 1);
      chk("byte B", rd, 32'hAAEE_CCDD);
      $display("map B or emulation done");
    end
    test_done();
  end
endmodule
